// ### logic/pstc_consts.svh
// Constants for the power-state controller
`ifndef PSTC_CONSTS_SVH
`define PSTC_CONSTS_SVH
`define PSTC_CLK_HZ        10000000
`define PSTC_OSC_SETTLE_NS 10000
// Least settle time rounded up to whole cycles, at least one
`define PSTC_OSC_SETTLE_CYC \
   ((((`PSTC_OSC_SETTLE_NS) * 10 + 999) / 1000) < 1 ? 1 : \
   (((`PSTC_OSC_SETTLE_NS) * 10 + 999) / 1000))
`define PSTC_CNT_W         8
`endif

// ### logic/pstc_pkg.sv
// Types for the power-state controller
package pstc_pkg;
   typedef enum logic [2:0]
   {
      PSTC_POWER_DOWN   = 3'h0,
      PSTC_PROC_ONLY    = 3'h1,
      PSTC_DEEP_SLEEP   = 3'h2,
      PSTC_RADIO_TX     = 3'h3,
      PSTC_RADIO_RX     = 3'h4
   } pstc_state_e;
   typedef enum logic [1:0]
   {
      PSTC_CMD_NONE  = 2'h0,
      PSTC_CMD_TX    = 2'h1,
      PSTC_CMD_RX    = 2'h2,
      PSTC_CMD_IDLE  = 2'h3
   } pstc_cmd_e;
endpackage

// ### logic/pstc_power_state_control.sv
// Device power-state sequencer driven by enable pin, wake pin and firmware
`timescale 1ns/1ps
`include "pstc_consts.svh"

module pstc_power_state_control
(
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   input  wire logic              io_supply_i,
   input  wire logic              enable_pin_i,
   input  wire logic              wake_control_pin_i,
   input  wire pstc_pkg::pstc_cmd_e sw_cmd_i,
   input  wire logic              sw_sleep_req_i,
   input  wire logic              radio_events_pending_i,
   output logic [2:0]             state_o,
   output logic                   proc_power_o,
   output logic                   radio_power_o,
   output logic                   radio_tx_o,
   output logic                   radio_rx_o,
   output logic                   lf_clk_valid_o
);
   import pstc_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] en_sync;
   logic [1:0] wake_sync;
   logic [1:0] sup_sync;
   logic       en_s;
   logic       wake_s;
   logic       sup_s;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         en_sync   <= 2'h0;
         wake_sync <= 2'h3;
         sup_sync  <= 2'h0;
      end
      else
      begin
         en_sync   <= {en_sync[0], enable_pin_i};
         wake_sync <= {wake_sync[0], wake_control_pin_i};
         sup_sync  <= {sup_sync[0], io_supply_i};
      end
   end

   assign en_s   = en_sync[1];
   assign wake_s = wake_sync[1];
   assign sup_s  = sup_sync[1];

   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   pstc_state_e state;
   pstc_state_e next_state;

   always_comb
   begin
      next_state = state;
      case (state)
         PSTC_POWER_DOWN:
         begin
            if (sup_s && en_s)
               next_state = PSTC_PROC_ONLY;
         end
         PSTC_PROC_ONLY:
         begin
            if (sw_sleep_req_i && !wake_s && !radio_events_pending_i)
               next_state = PSTC_DEEP_SLEEP;
            else if (sw_cmd_i == PSTC_CMD_TX)
               next_state = PSTC_RADIO_TX;
            else if (sw_cmd_i == PSTC_CMD_RX)
               next_state = PSTC_RADIO_RX;
         end
         PSTC_DEEP_SLEEP:
         begin
            if (wake_s)
               next_state = PSTC_PROC_ONLY;
         end
         PSTC_RADIO_TX, PSTC_RADIO_RX:
         begin
            if (sw_cmd_i == PSTC_CMD_IDLE)
               next_state = PSTC_PROC_ONLY;
            else if (sw_cmd_i == PSTC_CMD_TX)
               next_state = PSTC_RADIO_TX;
            else if (sw_cmd_i == PSTC_CMD_RX)
               next_state = PSTC_RADIO_RX;
         end
         default:
            next_state = PSTC_POWER_DOWN;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
         state <= PSTC_POWER_DOWN;
      else
         state <= next_state;
   end

   // ------------------------------------------------------------
   // Registered power outputs
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         state_o       <= 3'h0;
         proc_power_o  <= 1'b0;
         radio_power_o <= 1'b0;
         radio_tx_o    <= 1'b0;
         radio_rx_o    <= 1'b0;
      end
      else
      begin
         state_o       <= next_state;
         proc_power_o  <= (next_state == PSTC_PROC_ONLY) ||
                          (next_state == PSTC_RADIO_TX) ||
                          (next_state == PSTC_RADIO_RX);
         radio_power_o <= (next_state == PSTC_RADIO_TX) ||
                          (next_state == PSTC_RADIO_RX);
         radio_tx_o    <= (next_state == PSTC_RADIO_TX);
         radio_rx_o    <= (next_state == PSTC_RADIO_RX);
      end
   end

   // ------------------------------------------------------------
   // Oscillator settle timer
   // ------------------------------------------------------------
   localparam logic [`PSTC_CNT_W-1:0] SETTLE_CYC = `PSTC_CNT_W'(`PSTC_OSC_SETTLE_CYC);
   logic [`PSTC_CNT_W-1:0] settle_cnt;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i || !en_s)
      begin
         settle_cnt     <= 8'h00;
         lf_clk_valid_o <= 1'b0;
      end
      else if (settle_cnt < SETTLE_CYC)
      begin
         settle_cnt     <= settle_cnt + 8'h01;
         lf_clk_valid_o <= 1'b0;
      end
      else
         lf_clk_valid_o <= 1'b1;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Cycles the synchronised enable has stayed high, held at its top value
   logic [`PSTC_CNT_W-1:0] en_run_cnt;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i || !en_s)
         en_run_cnt <= 8'h00;
      else if (en_run_cnt != 8'hFF)
         en_run_cnt <= en_run_cnt + 8'h01;
   end

   sequence en_high_run_s;
      en_s [*8];
   endsequence

   proc_with_radio_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      radio_power_o |-> proc_power_o)
      else $error("radio powered without processor");

   down_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state == PSTC_POWER_DOWN && !en_s) |=> state == PSTC_POWER_DOWN)
      else $error("left power-down with enable low");

   power_up_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state == PSTC_POWER_DOWN && en_s && sup_s) |=> proc_power_o)
      else $error("enable high did not power processor");

   enable_ignored_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state != PSTC_POWER_DOWN && $fell(en_s)) |=> state != PSTC_POWER_DOWN)
      else $error("enable pin forced a transition after start");

   wake_block_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state != PSTC_DEEP_SLEEP && wake_s) |=> state != PSTC_DEEP_SLEEP)
      else $error("entered deep sleep with wake high");

   sleep_entry_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state == PSTC_PROC_ONLY && sw_sleep_req_i && !wake_s && !radio_events_pending_i)
      |=> state == PSTC_DEEP_SLEEP ##1 state_o == 3'h2)
      else $error("deep sleep not entered");

   sleep_exit_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state == PSTC_DEEP_SLEEP && wake_s) |=> state == PSTC_PROC_ONLY)
      else $error("deep sleep not left on wake");

   settle_time_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (en_high_run_s ##1 en_s [*8]) |-> !lf_clk_valid_o || settle_cnt == SETTLE_CYC)
      else $error("clock valid before settle time");

   settle_done_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (en_run_cnt > SETTLE_CYC) |-> lf_clk_valid_o)
      else $error("clock valid never raised");

   settle_early_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      lf_clk_valid_o |-> (en_run_cnt > SETTLE_CYC))
      else $error("clock valid before enable settle count");

   sleep_pending_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (state == PSTC_PROC_ONLY && radio_events_pending_i) |=> state != PSTC_DEEP_SLEEP)
      else $error("entered deep sleep with radio events pending");
endmodule

// ### tb/pstc_board_model.sv
// Board-side model driving the supply, enable and wake pins
`timescale 1ns/1ps
module pstc_board_model
(
   input  wire logic core_clk_i,
   input  wire logic power_req_i,
   input  wire logic en_req_i,
   input  wire logic wake_req_i,
   output logic      io_supply_o = 1'b0,
   output logic      enable_pin_o = 1'b0,
   output logic      wake_control_pin_o = 1'b1
);
   // Supply falls only once enable is already low
   always_ff @(posedge core_clk_i)
   begin
      if (power_req_i)
         io_supply_o <= 1'b1;
      else if (!enable_pin_o)
         io_supply_o <= 1'b0;
   end
   // Enable always driven, never ahead of the supply
   always_ff @(posedge core_clk_i)
   begin
      enable_pin_o <= en_req_i && power_req_i && io_supply_o;
   end
   always_ff @(posedge core_clk_i)
   begin
      wake_control_pin_o <= wake_req_i;
   end
endmodule

// ### tb/pstc_testbench.sv
// Self-checking bench for the power-state controller
`timescale 1ns/1ps
module testbench;
   import pstc_pkg::*;
   typedef struct packed {logic en; logic wk; pstc_cmd_e cmd; logic slp; logic evt;
      logic [2:0] st;} pstc_row_s;
   logic       core_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       pwr = 1'b1, en = 1'b0, wake = 1'b1, slp = 1'b0, evt = 1'b0;
   pstc_cmd_e  cmd = PSTC_CMD_NONE;
   logic       sup, enp, wkp, pp, rp, tx, rx, lfv;
   logic [2:0] st;
   logic [7:0] obs;
   int         err_total = 0, cmp_count = 0, cyc = 0;
   pstc_row_s  rows [10];
   assign obs = {1'b0, st, pp, rp, tx, rx};
   initial
   begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   pstc_board_model i_pstc_board_model (.core_clk_i(core_clk_i), .power_req_i(pwr),
      .en_req_i(en), .wake_req_i(wake), .io_supply_o(sup), .enable_pin_o(enp),
      .wake_control_pin_o(wkp));
   pstc_power_state_control i_pstc_power_state_control (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .io_supply_i(sup), .enable_pin_i(enp), .wake_control_pin_i(wkp),
      .sw_cmd_i(cmd), .sw_sleep_req_i(slp), .radio_events_pending_i(evt), .state_o(st),
      .proc_power_o(pp), .radio_power_o(rp), .radio_tx_o(tx), .radio_rx_o(rx),
      .lf_clk_valid_o(lfv));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] exp_of(input logic [2:0] s);
      return {1'b0, s, s == 3'h1 || s == 3'h3 || s == 3'h4, s == 3'h3 || s == 3'h4,
         s == 3'h3, s == 3'h4};
   endfunction
   task check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         stop_test();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rows[0] = '{1, 1, PSTC_CMD_TX, 0, 0, 3'h3};
      rows[1] = '{1, 1, PSTC_CMD_IDLE, 0, 0, 3'h1};
      rows[2] = '{1, 1, PSTC_CMD_RX, 0, 0, 3'h4};
      rows[3] = '{1, 1, PSTC_CMD_IDLE, 0, 0, 3'h1};
      rows[4] = '{1, 1, PSTC_CMD_NONE, 1, 0, 3'h1};
      rows[5] = '{1, 0, PSTC_CMD_NONE, 1, 1, 3'h1};
      rows[6] = '{1, 0, PSTC_CMD_NONE, 1, 0, 3'h2};
      rows[7] = '{1, 0, PSTC_CMD_TX, 0, 0, 3'h2};
      rows[8] = '{1, 1, PSTC_CMD_NONE, 0, 0, 3'h1};
      rows[9] = '{0, 1, PSTC_CMD_NONE, 0, 0, 3'h1};
      tick(8);
      check({lfv, obs[6:0]}, 8'h00);
      srst_i = 1'b0;
      tick(10);
      check({lfv, obs[6:0]}, 8'h00);
      en = 1'b1;
      tick(3);
      check(obs, exp_of(3'h0));
      tick(1);
      check(obs, exp_of(3'h1));
      tick(99);
      check({7'h00, lfv}, 8'h00);
      tick(1);
      check({7'h00, lfv}, 8'h01);
      $display("test power_up done");
      foreach (rows[i])
      begin
         en = rows[i].en;
         wake = rows[i].wk;
         cmd = rows[i].cmd;
         slp = rows[i].slp;
         evt = rows[i].evt;
         tick(5);
         check(obs, exp_of(rows[i].st));
      end
      check({7'h00, lfv}, 8'h00);
      $display("test firmware_rows done");
      srst_i = 1'b1;
      tick(2);
      check({lfv, obs[6:0]}, 8'h00);
      srst_i = 1'b0;
      tick(5);
      check({lfv, obs[6:0]}, 8'h00);
      en = 1'b1;
      tick(3);
      check(obs, exp_of(3'h0));
      tick(1);
      check(obs, exp_of(3'h1));
      $display("test mid_reset done");
      stop_test();
   end
endmodule
